// ==== include/pfs_defs.svh ====
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// Clock
`define PFS_CLK_MHZ 50

// Sample scale: one code step is one volt of line or link
`define PFS_CODE_W 10
`define PFS_PEAK_CLAMP_V 10'h0080
`define PFS_PEAK_STEP_V 10'h0005
`define PFS_BO_LOWER_V 10'h005F
`define PFS_BO_UPPER_V 10'h0069
`define PFS_LINK_NOM_V 10'h0190
`define PFS_STARTUP_V 10'h0168
`define PFS_OVP_V 10'h01A4
`define PFS_OVP_HYS_V 10'h0014

// Times in their own units
`define PFS_TROUGH_MS 8
`define PFS_BO_MS 56
`define PFS_RETRY_S 3
`define PFS_SU_LIMIT_MS 496
`define PFS_NM_CLEAR_MS 1024
`define PFS_TON_UVS 1126

// Derived cycle counts
`define PFS_TROUGH_CYCLES (`PFS_TROUGH_MS * 1000 * `PFS_CLK_MHZ)
`define PFS_BO_CYCLES (`PFS_BO_MS * 1000 * `PFS_CLK_MHZ)
`define PFS_RETRY_CYCLES (`PFS_RETRY_S * 1000000 * `PFS_CLK_MHZ)
`define PFS_SU_TROUGHS (`PFS_SU_LIMIT_MS / `PFS_TROUGH_MS)
`define PFS_NM_TROUGHS (`PFS_NM_CLEAR_MS / `PFS_TROUGH_MS)
`define PFS_TON_VCYC (`PFS_TON_UVS * `PFS_CLK_MHZ)
`define PFS_OP_CYCLES 3'h4

// Counter widths
`define PFS_TICK_W 19
`define PFS_BO_W 22
`define PFS_RETRY_W 28

`endif

// ==== include/pfs_pkg.sv ====
`include "pfs_defs.svh"

package pfs_pkg;

	typedef enum logic [1:0] {PFS_RUN, PFS_BROWN, PFS_OVERP, PFS_SLEEP} pfs_mode_type;

	typedef struct packed {
		logic startup;
		logic brownout;
		logic overpower;
		logic overvoltage;
		logic loop_fault;
		logic low_power;
	} pfs_status_type;

	typedef struct packed {
		pfs_mode_type mode;
		logic [`PFS_CODE_W-1:0] line_s;
		logic [`PFS_CODE_W-1:0] link_s;
		logic [`PFS_CODE_W-1:0] peak;
		logic [`PFS_TICK_W-1:0] tick_cnt;
		logic [`PFS_BO_W-1:0] lo_cnt;
		logic [`PFS_BO_W-1:0] hi_cnt;
		logic [`PFS_RETRY_W-1:0] retry_cnt;
		logic [7:0] su_cnt;
		logic [7:0] nm_cnt;
		logic [2:0] cyc_cnt;
		logic retry_win;
		logic startup;
		logic ovp;
		logic loop_fault;
		logic gate;
		logic ton_over;
	} pfs_state_type;

endpackage

// ==== src/pfs_fault_supervisor.sv ====
// Behaviour
// - Filtered line peak above 128 V is clamped to 128 V within half cycle.
// - After clamping, filtered peak drops 5 V at each trough, every 8 ms.
// - Line below lower threshold starts timer; brownout and gate off after 56 ms.
// - Brownout ends after line peak above upper threshold for 56 ms, or when the remote sleep input selects sleep.
// - During brownout, a gate-drive restart is attempted every 3 seconds.
// - Link below start-up threshold selects start-up; nominal link returns normal.
// - Repeated start-up and normal alternation declares overpower.
// - Staying in start-up beyond a set time declares overpower.
// - Overpower stops gate, enters low power, retries every 3 seconds.
// - Intermittent disturbances latch nothing; regulation continues.
// - Link above 105% of reference stops gate at once, unfiltered.
// - After overvoltage, switching resumes below threshold minus hysteresis.
// - Link measurement below line measurement stops gate drive.
// - Loop fault clears when link at least line and above line peak.
// - Failed link sensing stops gate within about 150 us.
// - Line sense at zero is handled through the brownout timing path.
// - On-time limit uses constant 0.001126 against the line voltage.
// - Start-up below 90% of nominal link, held until 100% reached.
module pfs_fault_supervisor
	import pfs_pkg::*;
#(
	parameter int unsigned TROUGH_CYCLES = `PFS_TROUGH_CYCLES,
	parameter int unsigned BO_CYCLES = `PFS_BO_CYCLES,
	parameter int unsigned RETRY_CYCLES = `PFS_RETRY_CYCLES
)
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_sample_valid,
	input wire logic [`PFS_CODE_W-1:0] i_line_sense_input,
	input wire logic [`PFS_CODE_W-1:0] i_link_sense_input,
	input wire logic i_remote_sleep_input_n,
	input wire logic [15:0] i_ton_cycles,
	output logic o_gate_drive_output,
	output logic o_ton_over,
	output pfs_status_type o_status
);

	localparam logic [`PFS_TICK_W-1:0] TICK_END = `PFS_TICK_W'(TROUGH_CYCLES - 1);
	localparam logic [`PFS_BO_W-1:0] BO_END = `PFS_BO_W'(BO_CYCLES);
	localparam logic [`PFS_RETRY_W-1:0] RETRY_END = `PFS_RETRY_W'(RETRY_CYCLES - 1);
	localparam logic [7:0] SU_END = 8'(`PFS_SU_TROUGHS);
	localparam logic [7:0] NM_END = 8'(`PFS_NM_TROUGHS);
	localparam logic [25:0] TON_LIMIT = 26'(`PFS_TON_VCYC);
	localparam logic [`PFS_CODE_W-1:0] OVP_LOW = `PFS_OVP_V - `PFS_OVP_HYS_V;

	pfs_state_type s;
	pfs_state_type next_s;

	logic tick;
	logic lo_trip;
	logic hi_ok;
	logic retry_done;
	logic op_trip;
	logic [`PFS_CODE_W-1:0] peak_dec;
	logic [25:0] ton_prod;

	always_comb
	begin
		next_s = s;
		tick = (s.tick_cnt == TICK_END);
		lo_trip = (s.lo_cnt == BO_END);
		hi_ok = (s.hi_cnt == BO_END);
		retry_done = (s.retry_cnt == RETRY_END);
		op_trip = (s.cyc_cnt == `PFS_OP_CYCLES) || (s.su_cnt == SU_END);
		ton_prod = 26'(s.line_s * i_ton_cycles);

		// Trough tick divider
		if (tick)
		begin
			next_s.tick_cnt = '0;
		end
		else
		begin
			next_s.tick_cnt = s.tick_cnt + 1'b1;
		end

		if (i_sample_valid)
		begin
			next_s.line_s = i_line_sense_input;
			next_s.link_s = i_link_sense_input;
		end

		// Peak filter with clamp and trough decay
		if (tick && (s.peak > `PFS_PEAK_STEP_V))
		begin
			peak_dec = s.peak - `PFS_PEAK_STEP_V;
		end
		else if (tick)
		begin
			peak_dec = '0;
		end
		else
		begin
			peak_dec = s.peak;
		end
		if (i_sample_valid && (i_line_sense_input > peak_dec))
		begin
			if (i_line_sense_input > `PFS_PEAK_CLAMP_V)
			begin
				next_s.peak = `PFS_PEAK_CLAMP_V;
			end
			else
			begin
				next_s.peak = i_line_sense_input;
			end
		end
		else
		begin
			next_s.peak = peak_dec;
		end

		// Low and high line timers
		if (s.peak >= `PFS_BO_LOWER_V)
		begin
			next_s.lo_cnt = '0;
		end
		else if (!lo_trip)
		begin
			next_s.lo_cnt = s.lo_cnt + 1'b1;
		end
		if (s.peak <= `PFS_BO_UPPER_V)
		begin
			next_s.hi_cnt = '0;
		end
		else if (!hi_ok)
		begin
			next_s.hi_cnt = s.hi_cnt + 1'b1;
		end

		// Start-up and normal mode
		if (i_sample_valid)
		begin
			if (i_link_sense_input < `PFS_STARTUP_V)
			begin
				next_s.startup = 1'b1;
			end
			else if (i_link_sense_input >= `PFS_LINK_NOM_V)
			begin
				next_s.startup = 1'b0;
			end
		end

		// Overpower watch
		if (s.startup && !next_s.startup && (s.cyc_cnt != `PFS_OP_CYCLES))
		begin
			next_s.cyc_cnt = s.cyc_cnt + 1'b1;
		end
		if (s.startup)
		begin
			next_s.nm_cnt = '0;
			if (tick && (s.su_cnt != SU_END))
			begin
				next_s.su_cnt = s.su_cnt + 1'b1;
			end
		end
		else
		begin
			next_s.su_cnt = '0;
			if (tick && (s.nm_cnt != NM_END))
			begin
				next_s.nm_cnt = s.nm_cnt + 1'b1;
			end
			if (s.nm_cnt == NM_END)
			begin
				next_s.cyc_cnt = '0;
			end
		end

		// Overvoltage cut-off
		if (i_sample_valid)
		begin
			if (i_link_sense_input > `PFS_OVP_V)
			begin
				next_s.ovp = 1'b1;
			end
			else if (i_link_sense_input < OVP_LOW)
			begin
				next_s.ovp = 1'b0;
			end
		end

		// Sense loop check
		if (i_sample_valid)
		begin
			if (i_link_sense_input < i_line_sense_input)
			begin
				next_s.loop_fault = 1'b1;
			end
			else if (i_link_sense_input > s.peak)
			begin
				next_s.loop_fault = 1'b0;
			end
		end

		// Restart interval
		if ((s.mode == PFS_BROWN) || (s.mode == PFS_OVERP))
		begin
			next_s.retry_cnt = retry_done ? '0 : s.retry_cnt + 1'b1;
		end
		else
		begin
			next_s.retry_cnt = '0;
		end

		unique case (s.mode)
			PFS_RUN:
			begin
				if (op_trip)
				begin
					next_s.mode = PFS_OVERP;
				end
				else if (lo_trip)
				begin
					next_s.mode = PFS_BROWN;
					next_s.retry_win = 1'b0;
				end
			end
			PFS_BROWN:
			begin
				if (hi_ok)
				begin
					next_s.mode = PFS_RUN;
					next_s.retry_win = 1'b0;
					next_s.su_cnt = '0;
					next_s.cyc_cnt = '0;
				end
				else if (retry_done)
				begin
					next_s.retry_win = 1'b1;
					next_s.lo_cnt = '0;
					next_s.startup = 1'b1;
					next_s.cyc_cnt = '0;
					next_s.su_cnt = '0;
				end
				else if (s.retry_win && lo_trip)
				begin
					next_s.retry_win = 1'b0;
				end
			end
			PFS_OVERP:
			begin
				if (retry_done)
				begin
					next_s.mode = PFS_RUN;
					next_s.startup = 1'b1;
					next_s.cyc_cnt = '0;
					next_s.su_cnt = '0;
					next_s.lo_cnt = '0;
				end
			end
			PFS_SLEEP:
			begin
				if (i_remote_sleep_input_n)
				begin
					next_s.mode = PFS_RUN;
					next_s.startup = 1'b1;
					next_s.cyc_cnt = '0;
					next_s.su_cnt = '0;
					next_s.lo_cnt = '0;
				end
			end
		endcase

		if (!i_remote_sleep_input_n)
		begin
			next_s.mode = PFS_SLEEP;
			next_s.retry_win = 1'b0;
		end

		// Gate enable
		next_s.gate = ((next_s.mode == PFS_RUN) || ((next_s.mode == PFS_BROWN) && next_s.retry_win))
			&& !next_s.ovp && !next_s.loop_fault;

		// On-time limit against line voltage
		next_s.ton_over = (ton_prod >= TON_LIMIT);
	end

	always_ff @(posedge i_mclk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s <= '{mode: PFS_RUN, startup: 1'b1, default: '0};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign o_gate_drive_output = s.gate;
	assign o_ton_over = s.ton_over;
	assign o_status.startup = s.startup;
	assign o_status.brownout = (s.mode == PFS_BROWN);
	assign o_status.overpower = (s.mode == PFS_OVERP);
	assign o_status.overvoltage = s.ovp;
	assign o_status.loop_fault = s.loop_fault;
	assign o_status.low_power = (s.mode == PFS_OVERP) || (s.mode == PFS_SLEEP);

endmodule

// ==== tb/pfs_fault_supervisor_props.sv ====
`include "pfs_defs.svh"
module pfs_props
	import pfs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_sample_valid,
	input wire logic [`PFS_CODE_W-1:0] i_line_sense_input,
	input wire logic [`PFS_CODE_W-1:0] i_link_sense_input,
	input wire logic i_remote_sleep_input_n,
	input wire logic [15:0] i_ton_cycles,
	input wire logic o_gate_drive_output,
	input wire logic o_ton_over,
	input wire pfs_status_type o_status
);
	timeunit 1ns;
	timeprecision 1ns;
	wire v = i_sample_valid;
	wire [9:0] lk = i_link_sense_input;
	wire g = o_gate_drive_output;
	wire pfs_status_type s = o_status;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	a_ovp_cut: assert property (v && lk > `PFS_OVP_V |=> !g && s.overvoltage)
		else $error("gate on at high link");
	a_ovp_resume: assert property (s.overvoltage && v && lk < `PFS_LINK_NOM_V |=> !s.overvoltage)
		else $error("overvoltage stuck");
	a_loop_cut: assert property (v && lk < i_line_sense_input |=> !g && s.loop_fault)
		else $error("loop fault missed");
	a_su_enter: assert property (v && lk < `PFS_STARTUP_V |=> s.startup)
		else $error("startup missed");
	a_su_leave:
		assert property (v && lk >= `PFS_LINK_NOM_V && i_remote_sleep_input_n && s[4:0] == 0 |=> !s.startup)
		else $error("startup stuck");
	a_sleep_stop: assert property (!i_remote_sleep_input_n |=> !g && s.low_power)
		else $error("sleep ignored");
	a_ton_limit:
		assert property (v ##1 1'b1 |=> o_ton_over == (32'($past(i_ton_cycles)) * $past(i_line_sense_input, 2)
		>= `PFS_TON_VCYC))
		else $error("on-time flag wrong");
	a_gate_clean: assert property (g |-> !s.overvoltage && !s.loop_fault && !s.overpower && !s.low_power)
		else $error("gate on in fault");
endmodule

bind pfs_fault_supervisor pfs_props i_pfs_props (.i_mclk, .i_nrst, .i_sample_valid, .i_line_sense_input,
	.i_link_sense_input, .i_remote_sleep_input_n, .i_ton_cycles, .o_gate_drive_output, .o_ton_over, .o_status);

// ==== tb/pfs_plant.sv ====
module pfs_plant
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_gate,
	input wire logic i_open,
	input wire logic [9:0] i_tgt,
	output logic o_valid,
	output logic [9:0] o_link
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] link;
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
		begin
			o_valid <= 1'b0;
			link <= 10'h00c8;
			o_link <= 10'h00c8;
		end
		else
		begin
			o_valid <= 1'b1;
			// Output charges only while switching
			if (i_gate && link < i_tgt)
				link <= link + 10'h0001;
			else if (link > i_tgt)
				link <= link - 10'h0001;
			o_link <= i_open ? o_link - (o_link > 10'h0002 ? 10'h0002 : o_link) : link;
		end
endmodule

// ==== tb/pfs_fault_supervisor_bench.sv ====
`define chk(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("BAD %0t %h %h", $time, a, b); end end
module pfs_fault_supervisor_bench
	import pfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic sleep_n = 1'b1;
	logic open = 1'b0;
	logic [9:0] amp = 10'h0078;
	logic [9:0] tgt = 10'h0190;
	logic [15:0] ton = 16'h0000;
	logic valid;
	logic gate;
	logic [9:0] link;
	pfs_status_type st;
	wire [6:0] obs = {gate, st};
	int fails = 0;
	int checked = 0;
	int exp_ovp = 0;
	int exp_ton = 0;
	int line_q = 0;
	logic ton_over;
	pfs_plant i_pfs_plant (.i_mclk(clk), .i_nrst(nrst), .i_gate(gate), .i_open(open), .i_tgt(tgt),
		.o_valid(valid), .o_link(link));
	pfs_fault_supervisor #(.TROUGH_CYCLES(50), .BO_CYCLES(300), .RETRY_CYCLES(2000)) i_pfs_fault_supervisor (
		.i_mclk(clk), .i_nrst(nrst), .i_sample_valid(valid), .i_line_sense_input(amp), .i_link_sense_input(link),
		.i_remote_sleep_input_n(sleep_n), .i_ton_cycles(ton), .o_gate_drive_output(gate), .o_ton_over(ton_over),
		.o_status(st));
	initial
		forever
			#10 clk = ~clk;
	always @(posedge clk)
		ton <= 16'($urandom % 32'h0000_0400);
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			exp_ovp = 0;
			exp_ton = 0;
			line_q = 0;
		end
		else
		begin
			// Flag uses the line held before this edge
			exp_ton = int'(line_q * ton >= `PFS_TON_VCYC);
			if (valid)
				line_q = amp;
			if (valid && link > `PFS_OVP_V)
				exp_ovp = 1;
			else if (valid && link < `PFS_LINK_NOM_V)
				exp_ovp = 0;
		end
		#1;
		`chk(st.overvoltage, exp_ovp[0])
		`chk(ton_over, exp_ton[0])
	end
	task automatic results();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	// Settled look away from the launching edge
	task automatic look(int b, logic v);
		@(negedge clk);
		`chk(obs[b], v)
		@(posedge clk);
	endtask
	task automatic waitst(int b, logic v, int lim);
		int n;
		n = 0;
		@(negedge clk);
		while (obs[b] !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		`chk(obs[b], v)
		@(posedge clk);
	endtask
	initial
	begin
		void'($urandom(32'h0000_cf11));
		tick(4);
		nrst <= 1'b1;
		tick(180);
		@(negedge clk);
		`chk(obs[6:5], 2'b11)
		waitst(5, 1'b0, 100);
		tgt <= 10'h01b8;
		repeat (20)
		begin
			tick(40);
			tgt <= 10'h017c + 10'($urandom % 32'h0000_003c);
		end
		for (int i = 0; i < 4 && !obs[3]; i++)
		begin
			tick(60);
			if (i == 2)
				look(3, 1'b0);
			tgt <= 10'h0154;
			waitst(5, 1'b1, 200);
			tgt <= 10'h019a;
		end
		waitst(3, 1'b1, 200);
		look(6, 1'b0);
		look(0, 1'b1);
		tgt <= 10'h0154;
		waitst(3, 1'b0, 2100);
		look(5, 1'b1);
		tgt <= 10'h0190;
		waitst(5, 1'b0, 300);
		tgt <= 10'h0154;
		waitst(3, 1'b1, 3400);
		tgt <= 10'h0190;
		waitst(3, 1'b0, 2100);
		waitst(5, 1'b0, 300);
		open <= 1'b1;
		waitst(1, 1'b1, 7500);
		look(6, 1'b0);
		open <= 1'b0;
		waitst(1, 1'b0, 20);
		sleep_n <= 1'b0;
		waitst(0, 1'b1, 2);
		look(6, 1'b0);
		sleep_n <= 1'b1;
		waitst(0, 1'b0, 2);
		amp <= 10'h00c8;
		tick(60);
		amp <= 10'h0000;
		tick(550);
		@(negedge clk);
		`chk(obs[4], 1'b0)
		waitst(4, 1'b1, 150);
		look(6, 1'b0);
		waitst(6, 1'b1, 2100);
		amp <= 10'h0078;
		tick(250);
		@(negedge clk);
		`chk(obs[4], 1'b1)
		waitst(4, 1'b0, 100);
		results();
	end
	initial
	begin
		#1000000;
		fails++;
		results();
	end
endmodule
